// ==== src/hcbfc_pkg.sv ====
// Functional notes
// - each dropped receive frame adds one to the 32-bit drop counter.
// - a host read of the drop counter returns the count, then zeroes it.
// - passing from 7fffffffh to 80000000h raises a halfway event.
// - writing one to command bit 31 starts an indirect MAC register access.
// - busy stays set during the access and clears itself on completion.
// - for a read, read data sits in the data register when busy clears.
// - command bit 30 picks direction: one reads, zero writes.
// - command bits 7 to 0 give the 8-bit MAC register index.
// - data register holds write value or receives the read value.
// - with the transmitter disabled, no pause frames and no back pressure.
// - high threshold field counts receive FIFO fill in 64-byte units.
// - fill reaching threshold triggers back pressure or pause per trigger bits.
// - full duplex sends exactly one pause frame with the MAC pause time.
// - half duplex jams each matching incoming frame for the set duration.
// - bits 7 to 4 choose jam duration, 5 us up to 602.2 us.
// - bit 0 triggers on any frame, overrides bits 3:1, enables pause.
`default_nettype none
package hcbfc_pkg;
	localparam logic [7:0] ADDR_DROP_COUNT = 8'ha0;
	localparam logic [7:0] ADDR_IND_COMMAND = 8'ha4;
	localparam logic [7:0] ADDR_IND_DATA = 8'ha8;
	localparam logic [7:0] ADDR_FLOW_CONFIG = 8'hac;

	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_RNW_BIT = 30;
	localparam int CMD_INDEX_LSB = 0;
	localparam int CMD_INDEX_W = 8;

	localparam int FLOW_HI_LSB = 16;
	localparam int FLOW_LO_LSB = 8;
	localparam int FLOW_DUR_LSB = 4;
	localparam int FLOW_ANY_BIT = 0;
	localparam int FLOW_ADDR_BIT = 1;
	localparam int FLOW_BCAST_BIT = 2;
	localparam int FLOW_MCAST_BIT = 3;

	localparam logic [31:0] DROP_COUNT_RESET = 32'h00000000;
	localparam logic [31:0] DROP_BELOW_HALF = 32'h7fffffff;
	localparam logic [31:0] DROP_HALF_VALUE = 32'h80000000;
	localparam logic [31:0] IND_DATA_RESET = 32'h00000000;
	localparam logic [7:0] IND_INDEX_RESET = 8'h00;
	localparam logic [7:0] FLOW_LEVEL_RESET = 8'h00;
	localparam logic [3:0] FLOW_NIBBLE_RESET = 4'h0;
	localparam logic [15:0] PAUSE_TIME_RESET = 16'h0000;

	localparam int FIFO_UNIT_BYTES = 64;
	localparam int FIFO_UNIT_SHIFT = $clog2(FIFO_UNIT_BYTES);

	localparam int CLK_PERIOD_NS = 40;
	localparam int BP_TICK_NS = 200;
	localparam int BP_TICK_CYC = BP_TICK_NS / CLK_PERIOD_NS;
	localparam int BP_EXTRA_10M_NS = 2200;
	localparam int BP_TICK_W = 12;
	localparam int BP_TIME_100M_NS [16] = '{5000, 10000, 15000, 25000, 50000, 100000,
		150000, 200000, 250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};

	// jam length in 200 ns ticks for a duration code and line rate
	function automatic logic [BP_TICK_W-1:0] bp_ticks(input logic [3:0] code,
		input logic is_100m);
		int ns;
		ns = BP_TIME_100M_NS[code] + (is_100m ? 0 : BP_EXTRA_10M_NS);
		bp_ticks = BP_TICK_W'(ns / BP_TICK_NS);
	endfunction

	typedef enum logic [0:0] {IND_IDLE, IND_WAIT} hcbfc_ind_state_t;

	typedef struct packed {
		logic [31:0] drop_count;
		logic drop_half;
		logic [31:0] rdata;
		hcbfc_ind_state_t ind_state;
		logic busy;
		logic rnw;
		logic [7:0] index;
		logic [31:0] data;
		logic mac_req;
		logic [7:0] flow_hi;
		logic [7:0] flow_lo;
		logic [3:0] bp_dur;
		logic [3:0] trig;
		logic pause_armed;
		logic pause_req;
		logic [15:0] pause_time;
		logic bp_out;
	} hcbfc_state_t;
endpackage
`default_nettype wire

// ==== src/hcbfc_bp_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcbfc_bp_timer #(
	parameter int TICK_CYC = hcbfc_pkg::BP_TICK_CYC,
	parameter int TICK_W = hcbfc_pkg::BP_TICK_W
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic [TICK_W-1:0] ticks_in,
	output logic active_out
);
	import hcbfc_pkg::*;

	if (TICK_CYC < 1 || TICK_CYC > 256 || TICK_W < 1) begin : g_chk
		$error("hcbfc_bp_timer: unsupported tick settings");
	end

	typedef struct packed {
		logic active;
		logic [7:0] pre;
		logic [TICK_W-1:0] cnt;
	} hcbfc_bp_state_t;

	localparam logic [7:0] PRE_LAST = 8'(TICK_CYC - 1);

	hcbfc_bp_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (abort_in) begin
			s_d.active = 1'b0;
		end else if (start_in) begin
			// active for ticks_in whole ticks
			s_d.active = 1'b1;
			s_d.pre = 8'h00;
			s_d.cnt = ticks_in - TICK_W'(1);
		end else if (s_q.active) begin
			if (s_q.pre == PRE_LAST) begin
				s_d.pre = 8'h00;
				if (s_q.cnt == '0) begin
					s_d.active = 1'b0;
				end else begin
					s_d.cnt = s_q.cnt - TICK_W'(1);
				end
			end else begin
				s_d.pre = s_q.pre + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign active_out = s_q.active;

	a_jam_min_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_q.active && !abort_in && !(s_q.pre == PRE_LAST && s_q.cnt == '0) |=>
		s_q.active)
		else $error("jam ended too early");
endmodule
`default_nettype wire

// ==== src/hcbfc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcbfc_top #(
	parameter int LEVEL_W = 14
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	input wire logic frame_dropped_in,
	output logic drop_half_event_out,
	output logic mac_req_out,
	output logic mac_rnw_out,
	output logic [7:0] mac_index_out,
	output logic [31:0] mac_wdata_out,
	input wire logic [31:0] mac_rdata_in,
	input wire logic mac_ack_in,
	input wire logic tx_enabled_in,
	input wire logic full_duplex_in,
	input wire logic speed_100_in,
	input wire logic [LEVEL_W-1:0] rx_fifo_level_in,
	input wire logic frame_start_in,
	input wire logic frame_multicast_in,
	input wire logic frame_broadcast_in,
	input wire logic frame_addr_match_in,
	input wire logic [15:0] pause_time_value_in,
	output logic pause_req_out,
	output logic [15:0] pause_time_out,
	output logic backpressure_out
);
	import hcbfc_pkg::*;

	if (LEVEL_W < FIFO_UNIT_SHIFT + 8) begin : g_chk
		$error("hcbfc_top: LEVEL_W too narrow for the high threshold");
	end

	localparam int UNIT_W = LEVEL_W - FIFO_UNIT_SHIFT;

	hcbfc_state_t s_q, s_d;

	logic rd_drop;
	logic wr_cmd;
	logic wr_data;
	logic wr_flow;
	logic [UNIT_W-1:0] fill_units;
	logic level_reached;
	logic frame_match;
	logic pause_fire;
	logic jam_start;
	logic jam_active;
	logic [BP_TICK_W-1:0] jam_ticks;

	always_comb begin
		rd_drop = 1'b0;
		wr_cmd = 1'b0;
		wr_data = 1'b0;
		wr_flow = 1'b0;
		if (reg_addr_in == ADDR_DROP_COUNT) begin
			rd_drop = reg_rd_in;
		end else if (reg_addr_in == ADDR_IND_COMMAND) begin
			wr_cmd = reg_wr_in;
		end else if (reg_addr_in == ADDR_IND_DATA) begin
			wr_data = reg_wr_in;
		end else if (reg_addr_in == ADDR_FLOW_CONFIG) begin
			wr_flow = reg_wr_in;
		end
	end

	// fill level in 64-byte units against the high threshold
	assign fill_units = rx_fifo_level_in[LEVEL_W-1:FIFO_UNIT_SHIFT];
	assign level_reached = fill_units >= UNIT_W'(s_q.flow_hi);

	// any-frame overrides the per-type selections
	assign frame_match = s_q.trig[FLOW_ANY_BIT] ||
		(s_q.trig[FLOW_MCAST_BIT] && frame_multicast_in) ||
		(s_q.trig[FLOW_BCAST_BIT] && frame_broadcast_in) ||
		(s_q.trig[FLOW_ADDR_BIT] && frame_addr_match_in);

	// one pause per threshold crossing, full duplex with any-frame only
	assign pause_fire = tx_enabled_in && full_duplex_in && s_q.trig[FLOW_ANY_BIT] &&
		level_reached && !s_q.pause_armed;

	assign jam_start = tx_enabled_in && !full_duplex_in && frame_start_in &&
		level_reached && frame_match;

	assign jam_ticks = bp_ticks(s_q.bp_dur, speed_100_in);

	always_comb begin
		s_d = s_q;
		s_d.drop_half = 1'b0;
		s_d.pause_req = 1'b0;

		// drop counter: clear on read, a drop in the read cycle still counts
		if (rd_drop) begin
			s_d.drop_count = frame_dropped_in ? 32'h00000001 : DROP_COUNT_RESET;
		end else if (frame_dropped_in) begin
			s_d.drop_count = s_q.drop_count + 32'h00000001;
			s_d.drop_half = (s_q.drop_count == DROP_BELOW_HALF);
		end

		// read data registered one cycle after the strobe
		s_d.rdata = 32'h00000000;
		if (reg_rd_in) begin
			if (reg_addr_in == ADDR_DROP_COUNT) begin
				s_d.rdata = s_q.drop_count;
			end else if (reg_addr_in == ADDR_IND_COMMAND) begin
				s_d.rdata[CMD_BUSY_BIT] = s_q.busy;
				s_d.rdata[CMD_RNW_BIT] = s_q.rnw;
				s_d.rdata[CMD_INDEX_LSB +: CMD_INDEX_W] = s_q.index;
			end else if (reg_addr_in == ADDR_IND_DATA) begin
				s_d.rdata = s_q.data;
			end else if (reg_addr_in == ADDR_FLOW_CONFIG) begin
				s_d.rdata[FLOW_HI_LSB +: 8] = s_q.flow_hi;
				s_d.rdata[FLOW_LO_LSB +: 8] = s_q.flow_lo;
				s_d.rdata[FLOW_DUR_LSB +: 4] = s_q.bp_dur;
				s_d.rdata[FLOW_ANY_BIT +: 4] = s_q.trig;
			end
		end

		// indirect access engine
		case (s_q.ind_state)
			IND_IDLE: begin
				// writes while busy are dropped to protect the access
				if (wr_cmd) begin
					s_d.rnw = reg_wdata_in[CMD_RNW_BIT];
					s_d.index = reg_wdata_in[CMD_INDEX_LSB +: CMD_INDEX_W];
					if (reg_wdata_in[CMD_BUSY_BIT]) begin
						s_d.busy = 1'b1;
						s_d.mac_req = 1'b1;
						s_d.ind_state = IND_WAIT;
					end
				end
				if (wr_data) begin
					s_d.data = reg_wdata_in;
				end
			end
			IND_WAIT: begin
				if (mac_ack_in) begin
					s_d.busy = 1'b0;
					s_d.mac_req = 1'b0;
					s_d.ind_state = IND_IDLE;
					if (s_q.rnw) begin
						s_d.data = mac_rdata_in;
					end
				end
			end
			default: begin
				s_d.ind_state = IND_IDLE;
			end
		endcase

		if (wr_flow) begin
			s_d.flow_hi = reg_wdata_in[FLOW_HI_LSB +: 8];
			s_d.flow_lo = reg_wdata_in[FLOW_LO_LSB +: 8];
			s_d.bp_dur = reg_wdata_in[FLOW_DUR_LSB +: 4];
			s_d.trig = reg_wdata_in[FLOW_ANY_BIT +: 4];
		end

		// rearm once the fill drops back below the threshold
		if (!level_reached) begin
			s_d.pause_armed = 1'b0;
		end else if (pause_fire) begin
			s_d.pause_armed = 1'b1;
		end
		if (pause_fire) begin
			s_d.pause_req = 1'b1;
			s_d.pause_time = pause_time_value_in;
		end

		s_d.bp_out = jam_active && tx_enabled_in;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q.drop_count <= DROP_COUNT_RESET;
			s_q.drop_half <= 1'b0;
			s_q.rdata <= 32'h00000000;
			s_q.ind_state <= IND_IDLE;
			s_q.busy <= 1'b0;
			s_q.rnw <= 1'b0;
			s_q.index <= IND_INDEX_RESET;
			s_q.data <= IND_DATA_RESET;
			s_q.mac_req <= 1'b0;
			s_q.flow_hi <= FLOW_LEVEL_RESET;
			s_q.flow_lo <= FLOW_LEVEL_RESET;
			s_q.bp_dur <= FLOW_NIBBLE_RESET;
			s_q.trig <= FLOW_NIBBLE_RESET;
			s_q.pause_armed <= 1'b0;
			s_q.pause_req <= 1'b0;
			s_q.pause_time <= PAUSE_TIME_RESET;
			s_q.bp_out <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	hcbfc_bp_timer #(
		.TICK_CYC(BP_TICK_CYC),
		.TICK_W(BP_TICK_W)
	) u_jam (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.start_in(jam_start),
		.abort_in(!tx_enabled_in || full_duplex_in),
		.ticks_in(jam_ticks),
		.active_out(jam_active)
	);

	assign reg_rdata_out = s_q.rdata;
	assign drop_half_event_out = s_q.drop_half;
	assign mac_req_out = s_q.mac_req;
	assign mac_rnw_out = s_q.rnw;
	assign mac_index_out = s_q.index;
	assign mac_wdata_out = s_q.data;
	assign pause_req_out = s_q.pause_req;
	assign pause_time_out = s_q.pause_time;
	assign backpressure_out = s_q.bp_out;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	a_drop_count_inc: assert property (frame_dropped_in && !rd_drop |=>
		s_q.drop_count == $past(s_q.drop_count) + 32'h00000001)
		else $error("drop counter did not step by one");

	a_drop_read_clear: assert property (rd_drop |=>
		reg_rdata_out == $past(s_q.drop_count) &&
		s_q.drop_count == ($past(frame_dropped_in) ? 32'h00000001 : 32'h00000000))
		else $error("drop counter read did not return and clear");

	a_drop_half_cause: assert property (drop_half_event_out |->
		s_q.drop_count == DROP_HALF_VALUE && $past(s_q.drop_count) == DROP_BELOW_HALF)
		else $error("halfway event without crossing");

	a_drop_half_seen: assert property (frame_dropped_in && !rd_drop &&
		s_q.drop_count == DROP_BELOW_HALF |=> drop_half_event_out ##1 !drop_half_event_out)
		else $error("halfway crossing missed");

	sequence s_cmd_start;
		wr_cmd && reg_wdata_in[CMD_BUSY_BIT] && !s_q.busy;
	endsequence

	sequence s_wait_ack;
		s_q.busy && mac_req_out && !mac_ack_in;
	endsequence

	a_cmd_start: assert property (s_cmd_start |=> mac_req_out && s_q.busy &&
		mac_rnw_out == $past(reg_wdata_in[CMD_RNW_BIT]))
		else $error("indirect access did not start");

	a_busy_holds: assert property (s_wait_ack |=> s_q.busy && mac_req_out)
		else $error("busy dropped before completion");

	a_busy_clears: assert property (s_q.busy && mac_ack_in |=> !s_q.busy && !mac_req_out)
		else $error("busy did not clear on completion");

	a_read_data_ready: assert property (s_q.busy && s_q.rnw && mac_ack_in |=>
		!s_q.busy && s_q.data == $past(mac_rdata_in))
		else $error("read data not in place when busy cleared");

	a_busy_guard: assert property (s_q.busy && (wr_cmd || wr_data) && !mac_ack_in |=>
		$stable(s_q.data) && $stable(s_q.index) && $stable(s_q.rnw))
		else $error("busy access changed by host write");

	a_req_fields: assert property (mac_req_out && !$rose(mac_req_out) |->
		$stable(mac_index_out) && $stable(mac_rnw_out) &&
		$stable(mac_wdata_out))
		else $error("request fields changed while pending");

	a_tx_off_quiet: assert property (!tx_enabled_in |=>
		!pause_req_out && !backpressure_out)
		else $error("flow action with transmitter disabled");

	a_pause_on_level: assert property (tx_enabled_in && full_duplex_in &&
		s_q.trig[FLOW_ANY_BIT] && fill_units >= UNIT_W'(s_q.flow_hi) && !s_q.pause_armed
		|=> pause_req_out && pause_time_out == $past(pause_time_value_in))
		else $error("pause frame not requested at threshold");

	sequence s_pause_held;
		pause_req_out && level_reached ##1 level_reached;
	endsequence

	a_single_pause: assert property (s_pause_held |-> !pause_req_out ##1 !pause_req_out)
		else $error("more than one pause per crossing");

	a_pause_needs_any: assert property (pause_req_out |-> $past(s_q.trig[FLOW_ANY_BIT]) &&
		$past(full_duplex_in))
		else $error("pause without any-frame selection");

	sequence s_jam_req;
		jam_start && !s_q.bp_out;
	endsequence

	a_jam_start: assert property (s_jam_req ##1 tx_enabled_in && !full_duplex_in |=>
		backpressure_out)
		else $error("matching frame not jammed");

	a_jam_level: assert property ($rose(backpressure_out) |->
		!$past(full_duplex_in, 2) && $past(jam_active))
		else $error("back pressure without half-duplex trigger");

	a_cmd_readback: assert property (reg_rd_in && reg_addr_in == ADDR_IND_COMMAND |=>
		reg_rdata_out == {$past(s_q.busy), $past(s_q.rnw), 22'h000000, $past(s_q.index)})
		else $error("command read back wrong");

	a_data_readback: assert property (reg_rd_in && reg_addr_in == ADDR_IND_DATA |=>
		reg_rdata_out == $past(s_q.data))
		else $error("data read back wrong");

	a_cmd_fields_store: assert property (wr_cmd && !s_q.busy |=>
		mac_index_out == $past(reg_wdata_in[CMD_INDEX_LSB +: CMD_INDEX_W]) &&
		mac_rnw_out == $past(reg_wdata_in[CMD_RNW_BIT]))
		else $error("command fields not stored");

	a_drop_no_write: assert property (reg_wr_in && reg_addr_in == ADDR_DROP_COUNT &&
		!frame_dropped_in |=> $stable(s_q.drop_count))
		else $error("drop counter changed by a write");

	a_flow_store: assert property (wr_flow |=>
		s_q.flow_hi == $past(reg_wdata_in[FLOW_HI_LSB +: 8]))
		else $error("high threshold not stored");

	a_pause_below: assert property (!level_reached |=>
		!pause_req_out)
		else $error("pause below threshold");

	a_pause_time_hold: assert property (!pause_req_out |->
		$stable(pause_time_out))
		else $error("pause time changed without request");

	a_jam_abort: assert property (!tx_enabled_in || full_duplex_in |=>
		!jam_active)
		else $error("jam kept running after abort");

	a_jam_fd_quiet: assert property (full_duplex_in ##1 full_duplex_in |=>
		!backpressure_out)
		else $error("back pressure in full duplex");
endmodule
`default_nettype wire

// ==== verif/hcbfc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcbfc_mac_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic rnw_in,
	input wire logic [7:0] index_in,
	input wire logic [31:0] wdata_in,
	input wire logic [7:0] delay_in,
	output logic [31:0] rdata_out,
	output logic ack_out
);
	logic [31:0] mem [256];
	logic [7:0] cnt_q;
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 256; i++) mem[i] <= {24'h5a0000, i[7:0]};
			cnt_q <= 8'h00;
			ack_out <= 1'b0;
			rdata_out <= 32'h00000000;
		end else if (ack_out || !req_in) begin
			cnt_q <= 8'h00;
			ack_out <= 1'b0;
			// idle read bus inverts its word every cycle, so the last word shows only every other cycle
			rdata_out <= ~rdata_out;
		end else if (cnt_q >= delay_in) begin
			ack_out <= 1'b1;
			if (rnw_in) rdata_out <= mem[index_in];
			else mem[index_in] <= wdata_in;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb_hcbfc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_hcbfc_top;
	import hcbfc_pkg::*;
	logic mclk_in = 0, rst_in = 1, wr = 0, rd = 0, drop = 0, txe = 0, fd = 0, s100 = 1;
	logic fs = 0, mc = 0, bc = 0, am = 0, mreq, mrnw, mack, half, preq, bp;
	logic [7:0] addr = 8'h00, midx, mdly = 8'h06;
	logic [31:0] wd = 32'h0, rdata, mwd, mrd, v;
	logic [13:0] lvl = 14'h0;
	logic [15:0] ptv = 16'h1234, pt;
	int failures = 0, compares = 0, cyc = 0, pcnt = 0, bcnt = 0, hcnt = 0, s;
	hcbfc_top dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
		.frame_dropped_in(drop), .drop_half_event_out(half), .mac_req_out(mreq),
		.mac_rnw_out(mrnw), .mac_index_out(midx), .mac_wdata_out(mwd),
		.mac_rdata_in(mrd), .mac_ack_in(mack), .tx_enabled_in(txe),
		.full_duplex_in(fd), .speed_100_in(s100), .rx_fifo_level_in(lvl),
		.frame_start_in(fs), .frame_multicast_in(mc), .frame_broadcast_in(bc),
		.frame_addr_match_in(am), .pause_time_value_in(ptv), .pause_req_out(preq),
		.pause_time_out(pt), .backpressure_out(bp));
	hcbfc_mac_model mac_u (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(mreq),
		.rnw_in(mrnw), .index_in(midx), .wdata_in(mwd), .delay_in(mdly),
		.rdata_out(mrd), .ack_out(mack));
	initial forever #20 mclk_in = ~mclk_in;
	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cyc++;
		pcnt += int'(preq === 1'b1);
		bcnt += int'(bp === 1'b1);
		hcnt += int'(half !== 1'b0);
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		// answer stands for the cycle after the strobe edge
		@(posedge mclk_in);
		d = rdata;
	endtask
	task automatic exp_rd(input string n, input logic [7:0] a, input logic [31:0] e);
		rd_reg(a, v);
		chk(n, e, v);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 50; i++) begin
			rd_reg(8'ha4, v);
			if (v[31] === 1'b0) break;
		end
	endtask
	task automatic frame(input logic m, input logic b, input int n);
		s = bcnt;
		@(posedge mclk_in);
		fs <= 1'b1;
		mc <= m;
		bc <= b;
		@(posedge mclk_in);
		fs <= 1'b0;
		repeat (n) @(posedge mclk_in);
	endtask
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		exp_rd("drop count", 8'ha0, 32'h0);
		exp_rd("command", 8'ha4, 32'h0);
		exp_rd("data", 8'ha8, 32'h0);
		exp_rd("flow cfg", 8'hac, 32'h0);
		exp_rd("unmapped", 8'hb0, 32'h0);
		$display("test reset done");
		@(posedge mclk_in);
		drop <= 1'b1;
		repeat (5) @(posedge mclk_in);
		drop <= 1'b0;
		exp_rd("drop count", 8'ha0, 32'h5);
		exp_rd("drop cleared", 8'ha0, 32'h0);
		@(posedge mclk_in);
		drop <= 1'b1;
		@(posedge mclk_in);
		drop <= 1'b0;
		wr_reg(8'ha0, 32'hffffffff);
		exp_rd("drop no write", 8'ha0, 32'h1);
		$display("test drop counter done");
		wr_reg(8'ha8, 32'hcafe0123);
		wr_reg(8'ha4, 32'h80000012);
		exp_rd("busy set", 8'ha4, 32'h80000012);
		chk("mac index", 32'h12, {24'h0, midx});
		chk("mac dir", 32'h0, {31'h0, mrnw});
		chk("mac wdata", 32'hcafe0123, mwd);
		wr_reg(8'ha8, 32'h0);
		wait_idle();
		chk("busy clear", 32'h00000012, v);
		exp_rd("data kept", 8'ha8, 32'hcafe0123);
		wr_reg(8'ha4, 32'hc0000034);
		exp_rd("busy rd", 8'ha4, 32'hc0000034);
		chk("mac dir rd", 32'h1, {31'h0, mrnw});
		wait_idle();
		exp_rd("read data", 8'ha8, 32'h5a000034);
		mdly <= 8'h00;
		wr_reg(8'ha4, 32'hc0000012);
		wait_idle();
		exp_rd("read back", 8'ha8, 32'hcafe0123);
		$display("test indirect access done");
		txe <= 1'b1;
		fd <= 1'b1;
		lvl <= 14'd127;
		wr_reg(8'hac, 32'h00020001);
		s = pcnt;
		repeat (10) @(posedge mclk_in);
		chk("pause below", 32'h0, 32'(pcnt - s));
		lvl <= 14'd128;
		repeat (10) @(posedge mclk_in);
		chk("pause once", 32'h1, 32'(pcnt - s));
		chk("pause time", 32'h1234, {16'h0, pt});
		lvl <= 14'd0;
		wr_reg(8'hac, 32'h0002000e);
		lvl <= 14'd128;
		s = pcnt;
		repeat (10) @(posedge mclk_in);
		chk("pause no bit0", 32'h0, 32'(pcnt - s));
		lvl <= 14'd0;
		txe <= 1'b0;
		wr_reg(8'hac, 32'h00020001);
		lvl <= 14'd200;
		repeat (10) @(posedge mclk_in);
		chk("pause tx off", 32'h0, 32'(pcnt - s));
		txe <= 1'b1;
		repeat (10) @(posedge mclk_in);
		chk("pause tx on", 32'h1, 32'(pcnt - s));
		$display("test pause done");
		fd <= 1'b0;
		lvl <= 14'd128;
		wr_reg(8'hac, 32'h00020008);
		frame(1'b0, 1'b1, 20);
		chk("jam bcast", 32'h0, 32'(bcnt - s));
		frame(1'b1, 1'b0, 140);
		chk("jam 100m", 32'd125, 32'(bcnt - s));
		s100 <= 1'b0;
		wr_reg(8'hac, 32'h00020018);
		frame(1'b1, 1'b0, 320);
		chk("jam 10m", 32'd305, 32'(bcnt - s));
		s100 <= 1'b1;
		wr_reg(8'hac, 32'h00020001);
		frame(1'b0, 1'b0, 140);
		chk("jam any", 32'd125, 32'(bcnt - s));
		lvl <= 14'd100;
		frame(1'b1, 1'b0, 20);
		chk("jam below", 32'h0, 32'(bcnt - s));
		lvl <= 14'd128;
		frame(1'b1, 1'b0, 10);
		chk("jam on", 32'h1, {31'h0, bp});
		txe <= 1'b0;
		repeat (3) @(posedge mclk_in);
		chk("jam abort", 32'h0, {31'h0, bp});
		$display("test back pressure done");
		chk("halfway events", 32'h0, 32'(hcnt));
		final_report();
	end
endmodule
`default_nettype wire
